// File: tmr_params.svh
// Purpose: Constants for the dual down-counting timer output and control block
// Assumes: Register index times four gives the Wishbone byte address
// Notes: Oscillator rates are plain defaults, not tied to any board
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

`define TMR_IDX_MODE 16'hffc0
`define TMR_IDX_OUTSRC 16'hffc1
`define TMR_IDX_CTRL0 16'hffc2
`define TMR_IDX_CTRL1 16'hffc3
`define TMR_IDX_RLD0_LO 16'hffc4
`define TMR_IDX_RLD0_HI 16'hffc5
`define TMR_IDX_RLD1_LO 16'hffc6
`define TMR_IDX_RLD1_HI 16'hffc7
`define TMR_IDX_CNT0_LO 16'hffc8
`define TMR_IDX_CNT0_HI 16'hffc9
`define TMR_IDX_CNT1_LO 16'hffca
`define TMR_IDX_CNT1_HI 16'hffcb
`define TMR_IDX_MASK 16'hffe2
`define TMR_IDX_FLAG 16'hfff2

`define TMR_BIT_POL 0
`define TMR_BIT_NR 1
`define TMR_BIT_T0_COUNTER_MODE 2
`define TMR_BIT_SRC0 0
`define TMR_BIT_SRC1 1
`define TMR_BIT_TOGGLE_OUTPUT_EN 2
`define TMR_BIT_OUTPUT_CHANNEL_SELECT 3
`define TMR_BIT_RUN 0
`define TMR_BIT_RELOAD 1
`define TMR_BIT_RATIO_LO 2

`define TMR_RST_NIBBLE 4'h0
`define TMR_RST_BYTE 8'h00

`define TMR_MCLK_HZ 50000000
`define TMR_LOW_OSC_HZ 32768
`define TMR_HIGH_OSC_HZ 4000000
`define TMR_LOW_OSC_DIV (`TMR_MCLK_HZ / `TMR_LOW_OSC_HZ)
`define TMR_HIGH_OSC_DIV (`TMR_MCLK_HZ / `TMR_HIGH_OSC_HZ)
`define TMR_NR_HZ 2048
`define TMR_NR_PRE (`TMR_LOW_OSC_HZ / `TMR_NR_HZ)
`define TMR_NR_TICKS 2

`define TMR_PRE_LIM_1 8'h00
`define TMR_PRE_LIM_4 8'h03
`define TMR_PRE_LIM_32 8'h1f
`define TMR_PRE_LIM_256 8'hff

`endif

// File: tmr_pkg.sv
// Purpose: Types shared by the timer block files
// Assumes: Nothing beyond the constants header
// Notes: Ratio codes follow the two-bit prescaler field
package tmr_pkg;
  typedef logic [3:0] nibble_t;
  typedef enum logic [1:0] {
    RATIO_1 = 2'h0,
    RATIO_4 = 2'h1,
    RATIO_32 = 2'h2,
    RATIO_256 = 2'h3
  } ratio_t;
endpackage

// File: timer_if.sv
// Purpose: Carrier between the control logic and one down counter
// Assumes: Single clock domain
// Notes: Load is a one-cycle pulse, underflow a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface timer_if;
  logic src_tick;
  tmr_pkg::ratio_t ratio;
  logic bypass;
  logic run;
  logic load;
  logic [7:0] reload;
  logic uflow;
  logic [7:0] count;
  modport ctl (output src_tick, ratio, bypass, run, load, reload, input uflow, count);
  modport tmr (input src_tick, ratio, bypass, run, load, reload, output uflow, count);
endinterface
`default_nettype wire

// File: timer_core.sv
// Purpose: Prescaler and 8-bit down counter with automatic reload
// Assumes: Source tick is a one-cycle enable on i_mclk
// Notes: Load wins over a count tick in the same cycle
`timescale 1ns/10ps
`default_nettype none
`include "tmr_params.svh"
module timer_core (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  timer_if.tmr t
);
  logic [7:0] pre_q;
  logic [7:0] lim;
  logic cnt_tick;
  logic [7:0] count_q;
  logic uflow_q;

  always_comb begin
    unique case (t.ratio)
      tmr_pkg::RATIO_1: lim = `TMR_PRE_LIM_1;
      tmr_pkg::RATIO_4: lim = `TMR_PRE_LIM_4;
      tmr_pkg::RATIO_32: lim = `TMR_PRE_LIM_32;
      tmr_pkg::RATIO_256: lim = `TMR_PRE_LIM_256;
    endcase
    if (t.bypass) begin
      lim = `TMR_PRE_LIM_1;
    end
  end

  assign cnt_tick = t.run && t.src_tick && (pre_q >= lim);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_q <= 8'h00;
    end else if (t.run && t.src_tick) begin
      pre_q <= (pre_q >= lim) ? 8'h00 : pre_q + 8'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_q <= `TMR_RST_BYTE;
    end else if (t.load) begin
      count_q <= t.reload;
    end else if (cnt_tick) begin
      count_q <= (count_q == 8'h00) ? t.reload : count_q - 8'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      uflow_q <= 1'b0;
    end else begin
      uflow_q <= !t.load && cnt_tick && (count_q == 8'h00);
    end
  end

  assign t.uflow = uflow_q;
  assign t.count = count_q;

  property p_load;
    @(posedge i_mclk) disable iff (!i_rst_b) t.load |=> count_q == $past(t.reload);
  endproperty
  a_load: assert property (p_load) else $error("Reload strobe did not load counter");

  property p_hold;
    @(posedge i_mclk) disable iff (!i_rst_b) (!t.run && !t.load) |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold) else $error("Stopped counter changed");

  property p_reload;
    @(posedge i_mclk) disable iff (!i_rst_b) (uflow_q && !$past(t.load)) |-> count_q == $past(t.reload);
  endproperty
  a_reload: assert property (p_reload) else $error("Counter not reloaded at underflow");

  property p_zero_reload;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (cnt_tick && !t.load && t.reload == 8'h00 && count_q == 8'h00) |=> uflow_q ##1 count_q == 8'h00;
  endproperty
  a_zero_reload: assert property (p_zero_reload) else $error("Zero reload mishandled");
endmodule
`default_nettype wire

// File: tmr_out_ctrl.sv
// Purpose: Register file, clock sources, event input, flags and outputs of two timers
// Assumes: Classic Wishbone slave, 32-bit data, nibble registers in bits 3:0
// Notes: Answers every access with ack one cycle after the request is seen
`timescale 1ns/10ps
`default_nettype none
`include "tmr_params.svh"
// Functional notes
// - Each timer underflow sets its flag and raises its interrupt request when its mask bit is 1.
// - A per-timer mask bit at 0 blocks that timer's interrupt request.
// - Flags are set by underflow regardless of the mask bit.
// - Toggle output changes level once per selected underflow.
// - Channel select 0 picks timer 0, 1 picks timer 1.
// - Enable 1 drives toggle onto the output pin, else pin stays high.
// - Enable gating is not synchronised to the toggle; glitches allowed.
// - Timer 1 underflows halved form the serial clock while timer 1 runs.
// - Reload zero is legal; serial period is 2 x (reload + 1) timer ticks.
// - Counter mode bit: 1 event counting, 0 timer; resets to 0.
// - Noise rejector on event input when set; event mode only; resets 0.
// - Polarity 0 counts falling edges, 1 counts rising edges.
// - Each prescaler source bit: 0 slow oscillator, 1 fast; reset 0.
// - Ratio codes 0..3 divide by 1, 4, 32, 256; reset 0.
// - Writing 1 to reset bit loads reload value; write-only.
// - Run bit starts or stops counting without altering the count.
// - Underflow reloads the counter and counting continues.
// - Timer 0 reload held as two nibbles; low nibble resets to 0.
module tmr_out_ctrl (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [17:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_event_input_pin,
  output logic o_general_output_pin,
  output logic o_sio_clk,
  output logic o_t0_irq,
  output logic o_t1_irq
);
  logic ack_q;
  logic [31:0] rdat_q;
  logic [15:0] idx;
  logic wr;
  logic [3:0] wdat;
  tmr_pkg::nibble_t rd_nib;
  logic t0_counter_mode_q;
  logic t0_noise_reject_enable_q;
  logic t0_edge_polarity_q;
  logic output_channel_select_q;
  logic toggle_output_enable_q;
  logic [1:0] src_sel_q;
  logic [1:0] run_q;
  tmr_pkg::ratio_t ratio_q [2];
  logic [7:0] reload_q [2];
  logic [1:0] irq_mask_q;
  logic [1:0] irq_flag_q;
  logic [1:0] flag_clr;
  logic [1:0] load;
  logic [1:0] uf;
  logic [7:0] cnt [2];
  logic [1:0] osc_tick;
  logic [3:0] nr_pre_q;
  logic tick2k;
  logic [2:0] ev_s_q;
  logic ev_ok;
  logic [1:0] nr_cnt_q;
  logic flt_q;
  logic flt_prev_q;
  logic ev_tick;
  logic toggle_output_q;
  logic sio_clk_q;
  logic pin_q;

  assign idx = i_wb_adr[17:2];
  assign wdat = i_wb_dat[3:0];
  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && ack_q && i_wb_sel[0];

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
    end
  end

  always_comb begin
    rd_nib = 4'h0;
    unique case (idx)
      `TMR_IDX_MODE: rd_nib = {1'b0, t0_counter_mode_q, t0_noise_reject_enable_q,
                               t0_edge_polarity_q};
      `TMR_IDX_OUTSRC: rd_nib = {output_channel_select_q, toggle_output_enable_q, src_sel_q};
      `TMR_IDX_CTRL0: rd_nib = {ratio_q[0], 1'b0, run_q[0]};
      `TMR_IDX_CTRL1: rd_nib = {ratio_q[1], 1'b0, run_q[1]};
      `TMR_IDX_RLD0_LO: rd_nib = reload_q[0][3:0];
      `TMR_IDX_RLD0_HI: rd_nib = reload_q[0][7:4];
      `TMR_IDX_RLD1_LO: rd_nib = reload_q[1][3:0];
      `TMR_IDX_RLD1_HI: rd_nib = reload_q[1][7:4];
      `TMR_IDX_CNT0_LO: rd_nib = cnt[0][3:0];
      `TMR_IDX_CNT0_HI: rd_nib = cnt[0][7:4];
      `TMR_IDX_CNT1_LO: rd_nib = cnt[1][3:0];
      `TMR_IDX_CNT1_HI: rd_nib = cnt[1][7:4];
      `TMR_IDX_MASK: rd_nib = {2'h0, irq_mask_q};
      `TMR_IDX_FLAG: rd_nib = {2'h0, irq_flag_q};
      default: rd_nib = 4'h0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdat_q <= 32'h0000_0000;
    end else if (i_wb_cyc && i_wb_stb && !ack_q) begin
      rdat_q <= {28'h000_0000, rd_nib};
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      t0_counter_mode_q <= 1'b0;
      t0_noise_reject_enable_q <= 1'b0;
      t0_edge_polarity_q <= 1'b0;
    end else if (wr && idx == `TMR_IDX_MODE) begin
      t0_counter_mode_q <= wdat[`TMR_BIT_T0_COUNTER_MODE];
      t0_noise_reject_enable_q <= wdat[`TMR_BIT_NR];
      t0_edge_polarity_q <= wdat[`TMR_BIT_POL];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      output_channel_select_q <= 1'b0;
      toggle_output_enable_q <= 1'b0;
      src_sel_q <= 2'h0;
    end else if (wr && idx == `TMR_IDX_OUTSRC) begin
      output_channel_select_q <= wdat[`TMR_BIT_OUTPUT_CHANNEL_SELECT];
      toggle_output_enable_q <= wdat[`TMR_BIT_TOGGLE_OUTPUT_EN];
      src_sel_q <= {wdat[`TMR_BIT_SRC1], wdat[`TMR_BIT_SRC0]};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_mask_q <= 2'h0;
    end else if (wr && idx == `TMR_IDX_MASK) begin
      irq_mask_q <= wdat[1:0];
    end
  end

  assign flag_clr = (wr && idx == `TMR_IDX_FLAG) ? wdat[1:0] : 2'h0;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_flag_q <= 2'h0;
    end else begin
      irq_flag_q <= uf | (irq_flag_q & ~flag_clr);
    end
  end

  assign o_t0_irq = irq_flag_q[0] & irq_mask_q[0];
  assign o_t1_irq = irq_flag_q[1] & irq_mask_q[1];

  // Event input: three-stage synchroniser, level accepted when stages 2 and 3 agree
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ev_s_q <= 3'h7;
    end else begin
      ev_s_q <= {ev_s_q[1:0], i_event_input_pin};
    end
  end
  assign ev_ok = ev_s_q[1] == ev_s_q[2];

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nr_pre_q <= 4'h0;
    end else if (osc_tick[0]) begin
      nr_pre_q <= nr_pre_q + 4'h1;
    end
  end
  assign tick2k = osc_tick[0] && (nr_pre_q == 4'(`TMR_NR_PRE - 1));

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flt_q <= 1'b1;
      nr_cnt_q <= 2'h0;
    end else if (!t0_noise_reject_enable_q) begin
      nr_cnt_q <= 2'h0;
      if (ev_ok) begin
        flt_q <= ev_s_q[2];
      end
    end else if (!ev_ok || ev_s_q[2] == flt_q) begin
      nr_cnt_q <= 2'h0;
    end else if (tick2k) begin
      if (nr_cnt_q == 2'(`TMR_NR_TICKS - 1)) begin
        flt_q <= ev_s_q[2];
        nr_cnt_q <= 2'h0;
      end else begin
        nr_cnt_q <= nr_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flt_prev_q <= 1'b1;
    end else begin
      flt_prev_q <= flt_q;
    end
  end

  assign ev_tick = t0_edge_polarity_q ? (flt_q && !flt_prev_q) : (!flt_q && flt_prev_q);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      localparam int unsigned DIV = (g == 0) ? `TMR_LOW_OSC_DIV : `TMR_HIGH_OSC_DIV;
      logic [10:0] div_q;
      timer_if tif ();

      always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          div_q <= 11'h000;
        end else if (osc_tick[g]) begin
          div_q <= 11'h000;
        end else begin
          div_q <= div_q + 11'h001;
        end
      end
      assign osc_tick[g] = div_q == 11'(DIV - 1);

      always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          ratio_q[g] <= tmr_pkg::RATIO_1;
          run_q[g] <= 1'b0;
        end else if (wr && idx == (`TMR_IDX_CTRL0 + 16'(g))) begin
          ratio_q[g] <= tmr_pkg::ratio_t'(wdat[`TMR_BIT_RATIO_LO +: 2]);
          run_q[g] <= wdat[`TMR_BIT_RUN];
        end
      end

      always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          reload_q[g] <= `TMR_RST_BYTE;
        end else if (wr && idx == (`TMR_IDX_RLD0_LO + 16'(2 * g))) begin
          reload_q[g][3:0] <= wdat;
        end else if (wr && idx == (`TMR_IDX_RLD0_HI + 16'(2 * g))) begin
          reload_q[g][7:4] <= wdat;
        end
      end

      assign load[g] = wr && idx == (`TMR_IDX_CTRL0 + 16'(g)) && wdat[`TMR_BIT_RELOAD];

      assign tif.bypass = (g == 0) && t0_counter_mode_q;
      assign tif.src_tick = tif.bypass ? ev_tick : osc_tick[src_sel_q[g]];
      assign tif.ratio = ratio_q[g];
      assign tif.run = run_q[g];
      assign tif.load = load[g];
      assign tif.reload = reload_q[g];
      assign uf[g] = tif.uflow;
      assign cnt[g] = tif.count;

      timer_core u_core (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .t(tif.tmr)
      );
    end
  endgenerate

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      toggle_output_q <= 1'b0;
    end else if (output_channel_select_q ? uf[1] : uf[0]) begin
      toggle_output_q <= !toggle_output_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sio_clk_q <= 1'b0;
    end else if (uf[1] && run_q[1]) begin
      sio_clk_q <= !sio_clk_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= toggle_output_enable_q ? toggle_output_q : 1'b1;
    end
  end

  assign o_general_output_pin = pin_q;
  assign o_sio_clk = sio_clk_q;

  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_ans;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  property p_wb_ack;
    @(posedge i_mclk) disable iff (!i_rst_b) s_req |=> s_ans;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("Bus answer not one cycle after request");

  property p_irq_req;
    @(posedge i_mclk) disable iff (!i_rst_b) (uf[1] && irq_mask_q[1]) |=> o_t1_irq;
  endproperty
  a_irq_req: assert property (p_irq_req) else $error("Underflow raised no request");

  property p_mask_block;
    @(posedge i_mclk) disable iff (!i_rst_b) !irq_mask_q[0] |-> !o_t0_irq;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("Masked request escaped");

  property p_flag_masked;
    @(posedge i_mclk) disable iff (!i_rst_b) (uf[0] && !irq_mask_q[0]) |=> irq_flag_q[0];
  endproperty
  a_flag_masked: assert property (p_flag_masked) else $error("Flag not set while masked");

  property p_toggle_t0;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (!output_channel_select_q && uf[0]) |=> toggle_output_q != $past(toggle_output_q);
  endproperty
  a_toggle_t0: assert property (p_toggle_t0) else $error("Toggle missed timer 0");

  property p_toggle_t1;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (output_channel_select_q && !uf[1]) |=> toggle_output_q == $past(toggle_output_q);
  endproperty
  a_toggle_t1: assert property (p_toggle_t1) else $error("Toggle moved without timer 1");

  property p_pin;
    @(posedge i_mclk) disable iff (!i_rst_b)
      !toggle_output_enable_q |=> o_general_output_pin ##1 o_general_output_pin || toggle_output_enable_q;
  endproperty
  a_pin: assert property (p_pin) else $error("Disabled pin not high");

  property p_sio;
    @(posedge i_mclk) disable iff (!i_rst_b) (uf[1] && run_q[1]) |=> o_sio_clk != $past(o_sio_clk);
  endproperty
  a_sio: assert property (p_sio) else $error("Serial clock did not toggle");

  property p_mode_wr;
    @(posedge i_mclk) disable iff (!i_rst_b)
      (wr && idx == `TMR_IDX_MODE) |=> t0_counter_mode_q == $past(i_wb_dat[`TMR_BIT_T0_COUNTER_MODE]);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("Mode bit write lost");

  property p_flag_hold;
    @(posedge i_mclk) disable iff (!i_rst_b) (irq_flag_q[0] && !flag_clr[0]) |=> irq_flag_q[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Flag cleared without write");
endmodule
`default_nettype wire

// File: link_partner.sv
// Purpose: Far-side model that drives the event line and times the clock outputs
// Assumes: The device drives its output pin at all times
// Notes: Periods are counted in i_mclk cycles between rising edges
`timescale 1ns/10ps
`default_nettype none
module link_partner (
  input wire logic i_mclk,
  input wire logic i_sio_clk,
  input wire logic i_pin,
  output logic o_event
);
  int n = 0;
  int rises[2] = '{0, 0};
  int last[2] = '{0, 0};
  int period[2] = '{0, 0};
  logic [1:0] prev = 2'h0;
  wire logic [1:0] cur = {i_pin, i_sio_clk};
  initial o_event = 1'b1;
  always @(posedge i_mclk) begin
    n <= n + 1;
    prev <= cur;
    for (int k = 0; k < 2; k++) begin
      if (cur[k] && !prev[k]) begin
        period[k] <= n - last[k];
        last[k] <= n;
        rises[k] <= rises[k] + 1;
      end
    end
  end
  // Sets the event line and holds it
  task automatic drive(input logic lvl, input int hold);
    @(posedge i_mclk);
    o_event <= lvl;
    repeat (hold) @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Purpose: Register-level tests of the timer output and control block
// Assumes: Wishbone ack comes one cycle after the request is taken
// Notes: Clock periods are measured by the partner model
`timescale 1ns/10ps
`default_nettype none
`include "tmr_params.svh"
module testbench;
  logic i_mclk, i_rst_b, req, we, ack, pin, sio, irq0, irq1, ev;
  logic [17:0] adr;
  logic [31:0] wdat, rdat, rv;
  int bad_count, check_count, s;
  int dv[4] = '{1, 4, 32, 256};
  logic [3:0] rl[4] = '{4'h2, 4'h2, 4'h0, 4'h0};
  tmr_out_ctrl dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_wb_cyc(req), .i_wb_stb(req),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_event_input_pin(ev), .o_general_output_pin(pin), .o_sio_clk(sio),
    .o_t0_irq(irq0), .o_t1_irq(irq1));
  link_partner partner (.i_mclk(i_mclk), .i_sio_clk(sio), .i_pin(pin), .o_event(ev));
  always #10 i_mclk = ~i_mclk;
  task automatic give_verdict;
    $display("mismatches %0d checks %0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic fail(input string m);
    bad_count++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
      fail(m);
  endtask
  task automatic wb(input logic [15:0] idx, input logic w, input logic [3:0] d);
    int c;
    @(posedge i_mclk);
    req <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {28'h0, d};
    c = 0;
    do begin
      @(posedge i_mclk);
      c++;
    end while (ack !== 1'b1 && c < 50);
    rv = rdat;
    req <= 1'b0;
    if (ack !== 1'b1) begin
      fail("no bus ack");
      give_verdict;
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [3:0] d);
    wb(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    wb(idx, 1'b0, 4'h0);
    chk(rv, exp, "register read");
  endtask
  task automatic wait_rise(input int k, input int lim);
    int b, c;
    b = partner.rises[k];
    c = 0;
    while (partner.rises[k] < b + 3 && c < lim) begin
      @(posedge i_mclk);
      c++;
    end
    if (c == lim) begin
      fail("no clock edges");
      give_verdict;
    end
  endtask
  task automatic set_t1(input logic [3:0] r, input logic [1:0] q);
    wr(`TMR_IDX_CTRL1, 4'h0);
    wr(`TMR_IDX_RLD1_LO, r);
    wr(`TMR_IDX_CTRL1, {q, 2'h3});
  endtask
  task automatic pulse;
    partner.drive(1'b0, 20);
    partner.drive(1'b1, 20);
  endtask
  initial begin
    i_mclk = 1'b0;
    i_rst_b = 1'b0;
    req = 1'b0;
    we = 1'b0;
    adr = 18'h0;
    wdat = 32'h0;
    bad_count = 0;
    check_count = 0;
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk({30'h0, pin, sio}, 32'h2, "pin or serial clock after reset");
    chk({30'h0, irq1, irq0}, 32'h0, "irq after reset");
    for (int i = 0; i < 5; i++)
      rd(16'hffc0 + 16'(i), 32'h0);
    rd(`TMR_IDX_FLAG, 32'h0);
    wr(`TMR_IDX_RLD0_LO, 4'ha);
    rd(`TMR_IDX_RLD0_LO, 32'ha);
    wr(`TMR_IDX_MODE, 4'hf);
    rd(`TMR_IDX_MODE, 32'h7);
    wr(`TMR_IDX_CTRL0, 4'he);
    rd(`TMR_IDX_CTRL0, 32'hc);
    wr(16'hffd0, 4'hf);
    rd(16'hffd0, 32'h0);
    // Event counting, both polarities
    wr(`TMR_IDX_RLD0_LO, 4'h3);
    wr(`TMR_IDX_MODE, 4'h4);
    wr(`TMR_IDX_CTRL0, 4'h3);
    partner.drive(1'b0, 20);
    rd(`TMR_IDX_CNT0_LO, 32'h2);
    partner.drive(1'b1, 20);
    rd(`TMR_IDX_CNT0_LO, 32'h2);
    wr(`TMR_IDX_MODE, 4'h5);
    partner.drive(1'b0, 20);
    rd(`TMR_IDX_CNT0_LO, 32'h2);
    partner.drive(1'b1, 20);
    rd(`TMR_IDX_CNT0_LO, 32'h1);
    wr(`TMR_IDX_CTRL0, 4'h0);
    pulse;
    rd(`TMR_IDX_CNT0_LO, 32'h1);
    wr(`TMR_IDX_CTRL0, 4'h1);
    pulse;
    rd(`TMR_IDX_CNT0_LO, 32'h0);
    pulse;
    rd(`TMR_IDX_CNT0_LO, 32'h3);
    rd(`TMR_IDX_FLAG, 32'h1);
    chk({31'h0, irq0}, 32'h0, "masked irq raised");
    // Short glitch, with and without the noise rejector
    wr(`TMR_IDX_MODE, 4'h6);
    partner.drive(1'b0, 100);
    partner.drive(1'b1, 100);
    rd(`TMR_IDX_CNT0_LO, 32'h3);
    wr(`TMR_IDX_MODE, 4'h4);
    pulse;
    rd(`TMR_IDX_CNT0_LO, 32'h2);
    // Flags and interrupt requests in timer mode
    wr(`TMR_IDX_CTRL0, 4'h0);
    wr(`TMR_IDX_FLAG, 4'h3);
    rd(`TMR_IDX_FLAG, 32'h0);
    wr(`TMR_IDX_MODE, 4'h0);
    wr(`TMR_IDX_OUTSRC, 4'h1);
    wr(`TMR_IDX_RLD0_LO, 4'h0);
    wr(`TMR_IDX_CTRL0, 4'h3);
    repeat (100) @(posedge i_mclk);
    wr(`TMR_IDX_CTRL0, 4'h0);
    rd(`TMR_IDX_FLAG, 32'h1);
    chk({31'h0, irq0}, 32'h0, "masked irq raised");
    wr(`TMR_IDX_MASK, 4'h1);
    repeat (2) @(posedge i_mclk);
    chk({31'h0, irq0}, 32'h1, "irq missing");
    wr(`TMR_IDX_FLAG, 4'h1);
    repeat (2) @(posedge i_mclk);
    chk({31'h0, irq0}, 32'h0, "irq not cleared");
    rd(`TMR_IDX_FLAG, 32'h0);
    // Serial clock over all ratio codes, rates kept at or below 1 MHz
    wr(`TMR_IDX_OUTSRC, 4'h2);
    for (int i = 0; i < 4; i++) begin
      set_t1(rl[i], 2'(i));
      wait_rise(0, 25000);
      s = 2 * (int'(rl[i]) + 1) * `TMR_HIGH_OSC_DIV * dv[i];
      chk(partner.period[0], s, "serial clock period");
    end
    wr(`TMR_IDX_OUTSRC, 4'h0);
    set_t1(4'h0, 2'h0);
    wait_rise(0, 12000);
    chk(partner.period[0], 2 * `TMR_LOW_OSC_DIV, "slow serial period");
    rd(`TMR_IDX_FLAG, 32'h2);
    chk({31'h0, irq1}, 32'h0, "masked t1 irq raised");
    wr(`TMR_IDX_MASK, 4'h2);
    repeat (2) @(posedge i_mclk);
    chk({31'h0, irq1}, 32'h1, "t1 irq missing");
    // Toggle output on the pin
    wr(`TMR_IDX_OUTSRC, 4'he);
    set_t1(4'h2, 2'h0);
    wait_rise(1, 1000);
    chk(partner.period[1], 2 * 3 * `TMR_HIGH_OSC_DIV, "toggle period");
    wr(`TMR_IDX_OUTSRC, 4'h2);
    repeat (3) @(posedge i_mclk);
    s = partner.rises[1];
    repeat (200) @(posedge i_mclk);
    chk({31'h0, pin}, 32'h1, "pin not high");
    chk(partner.rises[1], s, "pin moved while off");
    wr(`TMR_IDX_OUTSRC, 4'h6);
    repeat (3) @(posedge i_mclk);
    s = partner.rises[1];
    repeat (200) @(posedge i_mclk);
    chk(partner.rises[1], s, "wrong channel on pin");
    give_verdict;
  end
endmodule
`default_nettype wire
